// >>> sim/sssr_ctrl_model.sv
// sssr_ctrl_model: bus controller that answers a service request line
// by a serial poll, a few cycles after it sees the request.
// assumes srq_oe is the device's open-drain pull, high while pulled.
`timescale 1ns/1ps
`default_nettype none
module sssr_ctrl_model #(
    parameter int DLY = 3
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic int_en,
    input wire logic srq_oe,
    output logic poll
);
    logic [3:0] wait_ff;
    logic armed_ff;

    // interrupt is honoured only once the host has enabled it, last
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wait_ff <= 4'h0;
            armed_ff <= 1'b1;
            poll <= 1'b0;
        end else begin
            poll <= 1'b0;
            if (!srq_oe) begin
                armed_ff <= 1'b1;
                wait_ff <= 4'h0;
            end else if (int_en && armed_ff) begin
                wait_ff <= wait_ff + 4'h1;
                // one poll per request edge; a slow host would wait longer
                if (wait_ff == 4'(DLY)) begin
                    poll <= 1'b1;
                    armed_ff <= 1'b0;
                end
            end
        end
    end
endmodule : sssr_ctrl_model
`default_nettype wire

// >>> sim/status_summary_service_request_tb.sv
// status_summary_service_request_tb: self-checking bench of sssr_top.
// assumes sssr_top latencies stay below the settle time used here.
`timescale 1ns/1ps
`default_nettype none
module status_summary_service_request_tb;
    import sssr_pkg::*;
    typedef struct {int sel; logic [15:0] val;} sssr_note_t;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic gpib = 1'b0;
    logic int_en = 1'b0;
    logic ctl_poll;
    sssr_cmd_t cmd_d = '0;
    sssr_cmd_t cmd_w;
    sssr_grp_cfg_t cfg [3] = '{default: '0};
    logic [15:0] cond [3] = '{default: '0};
    logic rd [3] = '{default: 1'b0};
    logic [7:0] std_en = 8'h00;
    logic [7:0] std_set = 8'h00;
    logic rd_std = 1'b0;
    logic errq = 1'b0;
    logic outbuf = 1'b0;
    logic [7:0] sb, pb, mask, std_ev;
    logic [15:0] ev [3];
    logic srq_o, srq_oe;
    sssr_note_t notes [$];
    event take;
    int num_errors = 0;
    int checks_done = 0;
    int cycles = 0;
    int k;
    logic [7:0] v;
    logic [7:0] sbw [3] = '{8'h80, 8'h08, 8'h02};

    assign cmd_w = sssr_cmd_t'({cmd_d[11:1], cmd_d.serial_poll | ctl_poll});

    sssr_top i_sssr_top (.CLK(clk), .RST(rst), .CE(1'b1), .GPIB_MODE(gpib),
        .CMD(cmd_w), .OPER_CFG(cfg[0]), .QUES_CFG(cfg[1]), .DEV_CFG(cfg[2]),
        .STD_ENABLE(std_en), .OPER_COND(cond[0]), .QUES_COND(cond[1]),
        .DEV_COND(cond[2]), .STD_EVENT_SET(std_set), .RD_OPER(rd[0]),
        .RD_QUES(rd[1]), .RD_DEV(rd[2]), .RD_STD(rd_std),
        .ERRQ_NOT_EMPTY(errq), .OUTBUF_NOT_EMPTY(outbuf),
        .STATUS_SUMMARY_BYTE(sb), .POLL_BYTE(pb), .SRQ_MASK(mask),
        .OPER_EVENT(ev[0]), .QUES_EVENT(ev[1]), .DEV_EVENT(ev[2]),
        .STD_EVENT(std_ev), .SRQ_O(srq_o), .SRQ_OE(srq_oe));

    sssr_ctrl_model i_sssr_ctrl_model (.clk(clk), .rst(rst),
        .int_en(int_en), .srq_oe(srq_oe), .poll(ctl_poll));

    initial begin
        forever #25 clk = ~clk;
    end

    function automatic logic [15:0] obs(input int sel);
        case (sel)
            0: obs = {8'h00, sb};
            1: obs = {8'h00, pb};
            2: obs = {8'h00, mask};
            3, 4, 5: obs = ev[sel-3];
            6: obs = {8'h00, std_ev};
            default: obs = {15'h0000, srq_oe};
        endcase
    endfunction : obs

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    // settle covers the 3-ff syncs plus the summary and request stages
    task automatic expect_(input int sel, input logic [15:0] val);
        sssr_note_t n;
        n.sel = sel;
        n.val = val;
        repeat (8) @(posedge clk);
        notes.push_back(n);
        ->take;
    endtask : expect_

    task automatic conclude();
        if (num_errors == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : conclude

    initial begin
        sssr_note_t n;
        forever begin
            @(take);
            @(negedge clk);
            n = notes.pop_front();
            check(obs(n.sel), n.val);
        end
    end

    always @(posedge clk) begin
        cycles++;
        if (cycles == 4000) begin
            num_errors++;
            conclude();
        end
    end

    task automatic mask_wr(input logic [7:0] d);
        @(posedge clk);
        cmd_d.srq_mask_wr <= 1'b1;
        cmd_d.srq_mask_data <= d;
        @(posedge clk);
        cmd_d.srq_mask_wr <= 1'b0;
    endtask : mask_wr

    initial begin
        v = 8'($urandom(32'hda4c));
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        expect_(2, 16'h0000);
        expect_(0, 16'h0000);
        for (int i = 0; i < 8; i++) begin
            mask_wr(8'(1 << i));
            expect_(2, 16'(8'(1 << i) & 8'hbf));
        end
        v = 8'($urandom());
        mask_wr(v);
        expect_(2, {8'h00, v & 8'hbf});
        mask_wr(8'h00);
        expect_(2, 16'h0000);
        // setup order: clear, clear events, masks, host interrupt last
        @(posedge clk);
        cmd_d.clr_status <= 1'b1;
        @(posedge clk);
        cmd_d.clr_status <= 1'b0;
        mask_wr(8'h10);
        gpib <= 1'b0;
        outbuf <= 1'b1;
        expect_(0, 16'h0050);
        expect_(7, 16'h0000);
        gpib <= 1'b1;
        expect_(7, 16'h0001);
        expect_(1, 16'h0050);
        int_en <= 1'b1;
        repeat (6) @(posedge clk);
        outbuf <= 1'b0;
        expect_(0, 16'h0000);
        expect_(1, 16'h0000);
        expect_(7, 16'h0000);
        mask_wr(8'h00);
        errq <= 1'b1;
        expect_(0, 16'h0004);
        expect_(7, 16'h0000);
        errq <= 1'b0;
        expect_(0, 16'h0000);
        for (int g = 0; g < 3; g++) begin
            k = int'($urandom_range(14, 0));
            cfg[g] <= '{enable: 16'(1 << k), ptr: 16'hffff, ntr: 16'h0000};
            @(posedge clk);
            cond[g] <= 16'(1 << k);
            expect_(3 + g, 16'(1 << k));
            expect_(0, {8'h00, sbw[g]});
            cond[g] <= 16'h0000;
            expect_(3 + g, 16'(1 << k));
            @(posedge clk);
            rd[g] <= 1'b1;
            @(posedge clk);
            rd[g] <= 1'b0;
            expect_(0, 16'h0000);
            cond[g] <= 16'h8000;
            expect_(3 + g, 16'h0000);
            cond[g] <= 16'h0000;
        end
        std_en <= 8'h08;
        for (int j = 0; j < 2; j++) begin
            @(posedge clk);
            std_set <= 8'h08;
            @(posedge clk);
            std_set <= 8'h00;
            expect_(6, 16'h0008);
            expect_(0, 16'h0020);
            @(posedge clk);
            if (j == 0) cmd_d.clr_status <= 1'b1;
            else rd_std <= 1'b1;
            @(posedge clk);
            cmd_d.clr_status <= 1'b0;
            rd_std <= 1'b0;
            expect_(0, 16'h0000);
        end
        repeat (4) @(posedge clk);
        conclude();
    end
endmodule : status_summary_service_request_tb
`default_nettype wire

// >>> src/sssr_group.sv
// sssr_group: one status group with condition sync, transition filter,
// latched event register and summary.
// assumes cfg and read strobes come from logic on CLK.
`timescale 1ns/1ps
`default_nettype none
module sssr_group #(
    parameter int W = 16,
    parameter bit SYNC = 1'b1
) (
    input wire logic CLK,
    input wire logic RST,
    input wire logic ce,
    input wire logic [W-1:0] cond_in,
    input wire logic [W-1:0] enable,
    input wire logic [W-1:0] ptr,
    input wire logic [W-1:0] ntr,
    input wire logic live_mask_ok,
    input wire logic [W-1:0] live_mask,
    input wire logic read_evt,
    input wire logic clr_status,
    output logic [W-1:0] event_q,
    output logic summary
);
    import sssr_pkg::*;
    logic [W-1:0] s1_ff, s2_ff, s3_ff, cond_ff;
    logic [W-1:0] rise, fall, hit, nxt_event;

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            s1_ff <= '0;
            s2_ff <= '0;
            s3_ff <= '0;
        end else if (ce) begin
            s1_ff <= cond_in;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
        end
    end

    // a bit is taken once two synchroniser stages agree
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            cond_ff <= '0;
        end else if (ce) begin
            for (int i = 0; i < W; i++) begin
                if (!SYNC) begin
                    cond_ff[i] <= cond_in[i];
                end else if (s2_ff[i] == s3_ff[i]) begin
                    cond_ff[i] <= s3_ff[i];
                end
            end
        end
    end

    logic [W-1:0] cond_new;
    always_comb begin
        cond_new = cond_ff;
        for (int i = 0; i < W; i++) begin
            if (!SYNC) begin
                cond_new[i] = cond_in[i];
            end else if (s2_ff[i] == s3_ff[i]) begin
                cond_new[i] = s3_ff[i];
            end
        end
        rise = cond_new & ~cond_ff;
        fall = ~cond_new & cond_ff;
        hit = ((rise & ptr) | (fall & ntr)) & live_mask; // R21 R7
        // a new hit in the clearing cycle survives the clear
        nxt_event = ((read_evt | clr_status) ? '0 : event_q) | hit; // R21 R17
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            event_q <= '0;
        end else if (ce) begin
            event_q <= nxt_event;
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            summary <= 1'b0;
        end else if (ce) begin
            summary <= |(nxt_event & enable); // R20
        end
    end

    event_latch_a: assert property (@(posedge CLK) disable iff (RST)
        ce && !read_evt && !clr_status |=>
        ((event_q & $past(event_q)) == $past(event_q))) // R21
        else $error("event bit dropped without a clear");
    summary_or_a: assert property (@(posedge CLK) disable iff (RST)
        summary == |(event_q & enable) || $changed(enable)) // R20
        else $error("group summary differs from and-or of event");
    unused_top_a: assert property (@(posedge CLK) disable iff (RST)
        ((event_q & ~live_mask) == '0) || !live_mask_ok) // R7
        else $error("unused group bit set");
endmodule : sssr_group
`default_nettype wire

// >>> src/sssr_pkg.sv
// sssr_pkg: shared constants and carrier types of the status summary and
// service request block.
// assumes command strobes on CLK and that the command parser decodes queries.
// What this block does
// R1 - drive the service request line while an enabled status byte bit is set; the line follows the request bit, which a serial poll clears
// R2 - service request line is driven only when the bus is in gpib mode
// R3 - under polling nothing is signalled; state is only returned on queries
// R4 - mask bit n enables status byte bit n of the same weight
// R5 - mask query returns the weighted sum of enabled positions
// R6 - operation and questionable groups 16 bits, byte and standard 8 bits
// R7 - bit 15 of every 16-bit group always reads zero
// R8 - status byte bit 0 always reads zero
// R9 - bit 1 set while any enabled device group event is set
// R10 - bit 2 shows the error queue is not empty, clears when empty
// R11 - bit 3 set while any enabled questionable event is set
// R12 - bit 4 set, after the 3-ff flag sync, while response data waits in output buffer
// R13 - bit 4 clears only after every buffered message has been read
// R14 - bit 5 set while any enabled standard event bit is set
// R15 - bit 6 shows the device is requesting service, seen by serial poll
// R16 - bit 7 set while any enabled operation event is set
// R17 - clearing a group event register clears its summary bit
// R18 - mask clears at power on and when a zero mask is written
// R19 - controller clears device, clears events, loads masks, then enables srq
// R20 - group summary is the or of event and enable bits
// R21 - event bit latches selected transitions, holds until read or clear
// R22 - status byte query leaves the summary register unchanged
// R23 - request bit is or of enabled bits 0-5 and 7, cleared by serial poll
package sssr_pkg;
    localparam int SSSR_WIDE_W = 16;
    localparam int SSSR_NARROW_W = 8;
    localparam int SSSR_BIT_DEV = 1;
    localparam int SSSR_BIT_ERRQ = 2;
    localparam int SSSR_BIT_QUES = 3;
    localparam int SSSR_BIT_MAV = 4;
    localparam int SSSR_BIT_STD = 5;
    localparam int SSSR_BIT_RQS = 6;
    localparam int SSSR_BIT_OPER = 7;
    localparam logic [7:0] SSSR_MASK_RESET = 8'h00;
    localparam logic [15:0] SSSR_WIDE_RESET = 16'h0000;
    localparam logic [15:0] SSSR_WIDE_LIVE = 16'h7fff;
    localparam logic [15:0] SSSR_PTR_PRESET = 16'h7fff;

    // one group's software-written setup
    typedef struct packed {
        logic [15:0] enable;
        logic [15:0] ptr;
        logic [15:0] ntr;
    } sssr_grp_cfg_t;

    // one-cycle strobes from the command parser
    typedef struct packed {
        logic clr_status;
        logic preset;
        logic srq_mask_wr;
        logic [7:0] srq_mask_data;
        logic serial_poll;
    } sssr_cmd_t;
endpackage : sssr_pkg

// >>> src/sssr_top.sv
// sssr_top: status byte summary, service request mask and request bit,
// with operation, questionable, standard event and device status groups.
// assumes a command parser on CLK that decodes queries into strobes and
// writes group setup; condition and buffer inputs may come from elsewhere.
`timescale 1ns/1ps
`default_nettype none
module sssr_top (
    input wire logic CLK,
    input wire logic RST,
    input wire logic CE,
    input wire logic GPIB_MODE,
    input wire sssr_pkg::sssr_cmd_t CMD,
    input wire sssr_pkg::sssr_grp_cfg_t OPER_CFG,
    input wire sssr_pkg::sssr_grp_cfg_t QUES_CFG,
    input wire sssr_pkg::sssr_grp_cfg_t DEV_CFG,
    input wire logic [7:0] STD_ENABLE,
    input wire logic [15:0] OPER_COND,
    input wire logic [15:0] QUES_COND,
    input wire logic [15:0] DEV_COND,
    input wire logic [7:0] STD_EVENT_SET,
    input wire logic RD_OPER,
    input wire logic RD_QUES,
    input wire logic RD_DEV,
    input wire logic RD_STD,
    input wire logic ERRQ_NOT_EMPTY,
    input wire logic OUTBUF_NOT_EMPTY,
    output logic [7:0] STATUS_SUMMARY_BYTE,
    output logic [7:0] POLL_BYTE,
    output logic [7:0] SRQ_MASK,
    output logic [15:0] OPER_EVENT,
    output logic [15:0] QUES_EVENT,
    output logic [15:0] DEV_EVENT,
    output logic [7:0] STD_EVENT,
    output logic SRQ_O,
    output logic SRQ_OE
);
    import sssr_pkg::*;

    logic [15:0] oper_evt, ques_evt, dev_evt;
    logic oper_sum, ques_sum, dev_sum;
    logic [7:0] std_ff, nxt_std;
    logic [7:0] mask_ff, nxt_sb, sb_ff;
    logic rqs_ff, nxt_rqs;
    logic mav_s1_ff, mav_s2_ff, mav_s3_ff, mav_ff;
    logic erq_s1_ff, erq_s2_ff, erq_s3_ff, erq_ff;

    function automatic logic [7:0] sssr_enabled(input logic [7:0] sb,
                                                input logic [7:0] m);
        // bit 6 never feeds itself
        sssr_enabled = sb & m & 8'hbf; // R4 R23
    endfunction : sssr_enabled

    sssr_group #(.W(SSSR_WIDE_W), .SYNC(1'b1)) u_oper (
        .CLK(CLK), .RST(RST), .ce(CE), .cond_in(OPER_COND),
        .enable(OPER_CFG.enable), .ptr(OPER_CFG.ptr), .ntr(OPER_CFG.ntr),
        .live_mask_ok(1'b1), .live_mask(SSSR_WIDE_LIVE), // R6 R7
        .read_evt(RD_OPER), .clr_status(CMD.clr_status),
        .event_q(oper_evt), .summary(oper_sum)
    );
    sssr_group #(.W(SSSR_WIDE_W), .SYNC(1'b1)) u_ques (
        .CLK(CLK), .RST(RST), .ce(CE), .cond_in(QUES_COND),
        .enable(QUES_CFG.enable), .ptr(QUES_CFG.ptr), .ntr(QUES_CFG.ntr),
        .live_mask_ok(1'b1), .live_mask(SSSR_WIDE_LIVE), // R6 R7
        .read_evt(RD_QUES), .clr_status(CMD.clr_status),
        .event_q(ques_evt), .summary(ques_sum)
    );
    sssr_group #(.W(SSSR_WIDE_W), .SYNC(1'b1)) u_dev (
        .CLK(CLK), .RST(RST), .ce(CE), .cond_in(DEV_COND),
        .enable(DEV_CFG.enable), .ptr(DEV_CFG.ptr), .ntr(DEV_CFG.ntr),
        .live_mask_ok(1'b1), .live_mask(SSSR_WIDE_LIVE),
        .read_evt(RD_DEV), .clr_status(CMD.clr_status),
        .event_q(dev_evt), .summary(dev_sum)
    );

    // standard event register: one-cycle set pulses, 8 bits, set wins
    always_comb begin
        nxt_std = ((RD_STD | CMD.clr_status) ? 8'h00 : std_ff)
                  | STD_EVENT_SET; // R6 R17 R21
    end
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            std_ff <= 8'h00;
        end else if (CE) begin
            std_ff <= nxt_std;
        end
    end

    // buffer and queue flags come from other logic, possibly unrelated clocks
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            mav_s1_ff <= 1'b0;
            mav_s2_ff <= 1'b0;
            mav_s3_ff <= 1'b0;
            erq_s1_ff <= 1'b0;
            erq_s2_ff <= 1'b0;
            erq_s3_ff <= 1'b0;
        end else if (CE) begin
            mav_s1_ff <= OUTBUF_NOT_EMPTY;
            mav_s2_ff <= mav_s1_ff;
            mav_s3_ff <= mav_s2_ff;
            erq_s1_ff <= ERRQ_NOT_EMPTY;
            erq_s2_ff <= erq_s1_ff;
            erq_s3_ff <= erq_s2_ff;
        end
    end
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            mav_ff <= 1'b0;
            erq_ff <= 1'b0;
        end else if (CE) begin
            // flag follows buffer level, so it drops only when all is read
            if (mav_s2_ff == mav_s3_ff) begin
                mav_ff <= mav_s3_ff; // R12 R13
            end
            if (erq_s2_ff == erq_s3_ff) begin
                erq_ff <= erq_s3_ff; // R10
            end
        end
    end

    // service request mask; a zero write clears it
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            mask_ff <= SSSR_MASK_RESET; // R18
        end else if (CE && CMD.srq_mask_wr) begin
            mask_ff <= CMD.srq_mask_data & 8'hbf; // R4 R18
        end
    end

    always_comb begin
        nxt_sb = 8'h00; // R8
        nxt_sb[SSSR_BIT_DEV] = dev_sum; // R9
        nxt_sb[SSSR_BIT_ERRQ] = erq_ff; // R10
        nxt_sb[SSSR_BIT_QUES] = ques_sum; // R11
        nxt_sb[SSSR_BIT_MAV] = mav_ff; // R12
        nxt_sb[SSSR_BIT_STD] = |(std_ff & STD_ENABLE); // R14 R20
        nxt_sb[SSSR_BIT_OPER] = oper_sum; // R16
    end

    // request bit is raised on a new enabled cause, cleared by serial poll;
    // a cause rising in the poll cycle keeps it set
    // judge the cause against the mask that stands after this edge, so a
    // mask write never leaves the request bit set for a dead cause
    logic [7:0] en_now, en_prev_ff, nxt_mask;
    assign nxt_mask = CMD.srq_mask_wr ? (CMD.srq_mask_data & 8'hbf)
                                      : mask_ff; // R4 R18
    assign en_now = sssr_enabled(nxt_sb, nxt_mask);
    always_comb begin
        nxt_rqs = rqs_ff;
        if (CMD.serial_poll) begin
            nxt_rqs = 1'b0; // R23
        end
        if (|(en_now & ~en_prev_ff) || (|en_now && !rqs_ff && !CMD.serial_poll
            && !(|en_prev_ff))) begin
            nxt_rqs = 1'b1; // R15 R23
        end
        if (!(|en_now)) begin
            nxt_rqs = 1'b0;
        end
    end
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            rqs_ff <= 1'b0;
            en_prev_ff <= 8'h00;
        end else if (CE) begin
            rqs_ff <= nxt_rqs;
            en_prev_ff <= en_now;
        end
    end

    // summary byte output; a status byte query reads it without side effect
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            sb_ff <= 8'h00;
        end else if (CE) begin
            sb_ff <= nxt_sb; // R22 R17
        end
    end
    logic [7:0] full_sb;
    always_comb begin
        full_sb = sb_ff;
        full_sb[SSSR_BIT_RQS] = |sssr_enabled(sb_ff, mask_ff); // R15
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            STATUS_SUMMARY_BYTE <= 8'h00;
            POLL_BYTE <= 8'h00;
            SRQ_MASK <= 8'h00;
            OPER_EVENT <= SSSR_WIDE_RESET;
            QUES_EVENT <= SSSR_WIDE_RESET;
            DEV_EVENT <= SSSR_WIDE_RESET;
            STD_EVENT <= 8'h00;
            SRQ_O <= 1'b0;
            SRQ_OE <= 1'b0;
        end else if (CE) begin
            STATUS_SUMMARY_BYTE <= full_sb;
            POLL_BYTE <= {sb_ff[7], rqs_ff, sb_ff[5:0]}; // R15
            SRQ_MASK <= mask_ff; // R5
            OPER_EVENT <= oper_evt; // R7
            QUES_EVENT <= ques_evt; // R7
            DEV_EVENT <= dev_evt;
            STD_EVENT <= std_ff;
            // srq line is asserted low on the bus; drive only in gpib mode
            SRQ_O <= 1'b0;
            SRQ_OE <= GPIB_MODE && rqs_ff; // R1 R2 R3
        end
    end

    bit0_zero_a: assert property (@(posedge CLK) disable iff (RST)
        STATUS_SUMMARY_BYTE[0] == 1'b0 && POLL_BYTE[0] == 1'b0) // R8
        else $error("status byte bit 0 not zero");
    srq_mode_a: assert property (@(posedge CLK) disable iff (RST)
        !GPIB_MODE && CE |=> !SRQ_OE) // R2 R3
        else $error("srq driven outside gpib mode");
    srq_drive_a: assert property (@(posedge CLK) disable iff (RST)
        CE && GPIB_MODE && rqs_ff |=> SRQ_OE && !SRQ_O) // R1
        else $error("srq not driven for pending request");
    mask_zero_a: assert property (@(posedge CLK) disable iff (RST)
        CE && CMD.srq_mask_wr && CMD.srq_mask_data == 8'h00
        |=> ##1 SRQ_MASK == 8'h00) // R18
        else $error("zero mask write did not clear mask");
    poll_clear_a: assert property (@(posedge CLK) disable iff (RST)
        CE && CMD.serial_poll && (en_now & ~en_prev_ff) == 8'h00
        |=> !rqs_ff) // R23
        else $error("serial poll did not clear request bit");
    rqs_cause_a: assert property (@(posedge CLK) disable iff (RST)
        rqs_ff |-> |sssr_enabled(sb_ff, mask_ff)) // R15 R23
        else $error("request bit without enabled cause");
    clear_sum_a: assert property (@(posedge CLK) disable iff (RST)
        CE && CMD.clr_status && STD_EVENT_SET == 8'h00
        |=> ##1 !sb_ff[SSSR_BIT_STD]) // R17 R14
        else $error("clear status left standard summary set");
    mav_follow_a: assert property (@(posedge CLK) disable iff (RST)
        CE && mav_s2_ff && mav_s3_ff |=> ##1 sb_ff[SSSR_BIT_MAV]) // R12
        else $error("message available not reported");
endmodule : sssr_top
`default_nettype wire
